// ### fupc_ctrl.v
/*
 * Flash unlock and protection controller: command, page select,
 * sector protect and clock-rate registers, and the array controls.
 * Assumes a register-file write/read strobe port shared by CPU and
 * debugger (dbg_sel marks debugger access) and a flash array that
 * acts on one-cycle erase and program pulses.
 */
`timescale 1ns/10ps
`include "fupc_map.vh"
module fupc_ctrl (
  input  wire        clk,
  input  wire        sys_rst,
  input  wire        reg_wr,
  input  wire        reg_rd,
  input  wire [11:0] reg_addr,
  input  wire [7:0]  reg_wdata,
  input  wire        dbg_sel,
  output reg  [7:0]  reg_rdata,
  input  wire        program_protect_bit,
  input  wire        readout_protect_bit,
  input  wire        mem_wr,
  input  wire        mem_rd,
  input  wire [15:0] mem_addr,
  input  wire [7:0]  mem_wdata,
  output wire        mem_rd_block,
  output wire        mem_wr_refused,
  output reg         fl_prog_r,
  output reg         fl_page_erase_r,
  output reg         fl_mass_erase_r,
  output reg  [15:0] fl_addr_r,
  output reg  [7:0]  fl_wdata_r,
  output wire        cpu_stall
);
  reg  [2:0]  state_r;
  reg  [2:0]  state_nxt;
  reg  [7:0]  page_sel_r;
  reg  [7:0]  active_page_r;
  reg  [7:0]  sect_prot_r;
  reg         prot_map_r;
  reg         open_mass_r;
  reg  [15:0] rate_r;
  reg         erase_op_r;
  reg         timer_start_r;
  reg  [15:0] timer_dur_r;
  wire        timer_busy;
  wire        timer_done;
  wire        wr_cmd;
  wire        wr_page;
  wire        in_prog;
  wire        in_info;
  wire [2:0]  act_sect;
  wire [2:0]  wr_sect;
  wire        act_sect_open;
  wire        wr_sect_open;
  wire        user_ok;
  wire        byte_ok;
  wire [15:0] erase_us;

  assign wr_cmd  = reg_wr && (reg_addr == `FUPC_ADDR_CMD);
  assign wr_page = reg_wr && (reg_addr == `FUPC_ADDR_PAGE);
  assign in_prog = (mem_addr < 16'h2000);
  // Information area never takes program or erase
  assign in_info = (mem_addr >= `FUPC_INFO_BASE);
  // Sector is one eighth of memory, one sector per two pages
  assign act_sect = active_page_r[3:1];
  assign wr_sect  = mem_addr[`FUPC_SECT_MSB:`FUPC_SECT_LSB];
  // Protect bits bind CPU only
  assign act_sect_open = dbg_sel || !sect_prot_r[act_sect];
  assign wr_sect_open  = dbg_sel || !sect_prot_r[wr_sect];
  assign user_ok = dbg_sel || program_protect_bit;
  // Byte program only into active page unless debugger
  assign byte_ok = (state_r == `FUPC_ST_OPEN) && in_prog && !in_info &&
                   user_ok && wr_sect_open && rate_r != 16'h0000 &&
                   (dbg_sel || open_mass_r ||
                    mem_addr[`FUPC_PAGE_MSB:`FUPC_PAGE_LSB] ==
                    active_page_r[3:0]);
  assign mem_wr_refused = mem_wr && !byte_ok;
  // Debugger reads of user code blocked under readout protection
  assign mem_rd_block = mem_rd && dbg_sel && readout_protect_bit &&
                        in_prog;
  assign cpu_stall = timer_busy || timer_start_r;
  assign erase_us = `FUPC_ERASE_MS * 16'd1000;

  fupc_timer u_timer (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .start    (timer_start_r),
    .rate_khz (rate_r),
    .dur_us   (timer_dur_r),
    .busy_r   (timer_busy),
    .done     (timer_done)
  );

  always @* begin
    state_nxt = state_r;
    case (state_r)
      `FUPC_ST_LOCKED: begin
        if (wr_cmd && reg_wdata == `FUPC_CMD_UNLOCK1) begin
          state_nxt = `FUPC_ST_UNLK1;
        end
      end
      `FUPC_ST_UNLK1: begin
        if (wr_cmd) begin
          state_nxt = (reg_wdata == `FUPC_CMD_UNLOCK2) ?
                      (dbg_sel ? `FUPC_ST_OPEN : `FUPC_ST_UNLK2) :
                      `FUPC_ST_LOCKED;
        end
      end
      `FUPC_ST_UNLK2: begin
        if (wr_page && !prot_map_r) begin
          state_nxt = (reg_wdata == page_sel_r) ? `FUPC_ST_OPEN :
                      `FUPC_ST_LOCKED;
        end else if (wr_cmd) begin
          state_nxt = `FUPC_ST_LOCKED;
        end
      end
      `FUPC_ST_OPEN: begin
        if (wr_cmd) begin
          state_nxt = `FUPC_ST_LOCKED;
          if (reg_wdata == `FUPC_CMD_PAGE_ERASE && user_ok &&
              act_sect_open && rate_r != 16'h0000) begin
            state_nxt = `FUPC_ST_BUSY;
          end
          if (reg_wdata == `FUPC_CMD_MASS_ERASE && dbg_sel &&
              rate_r != 16'h0000) begin
            state_nxt = `FUPC_ST_BUSY;
          end
        end else if (mem_wr && byte_ok) begin
          state_nxt = `FUPC_ST_BUSY;
        end
      end
      `FUPC_ST_BUSY: begin
        if (timer_done) begin
          // Erase relocks; byte program keeps the page open
          state_nxt = erase_op_r ? `FUPC_ST_LOCKED :
                      `FUPC_ST_OPEN;
        end
      end
      default: state_nxt = `FUPC_ST_LOCKED;
    endcase
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      state_r         <= `FUPC_ST_LOCKED;
      page_sel_r      <= 8'h00;
      active_page_r   <= 8'h00;
      sect_prot_r     <= `FUPC_RST_PROT;
      prot_map_r      <= 1'b0;
      open_mass_r     <= 1'b0;
      rate_r          <= `FUPC_RST_RATE;
      erase_op_r      <= 1'b0;
      timer_start_r   <= 1'b0;
      timer_dur_r     <= 16'h0000;
      fl_prog_r       <= 1'b0;
      fl_page_erase_r <= 1'b0;
      fl_mass_erase_r <= 1'b0;
      fl_addr_r       <= 16'h0000;
      fl_wdata_r      <= 8'h00;
    end else begin
      state_r         <= state_nxt;
      timer_start_r   <= 1'b0;
      fl_prog_r       <= 1'b0;
      fl_page_erase_r <= 1'b0;
      fl_mass_erase_r <= 1'b0;
      if (wr_cmd) begin
        prot_map_r <= (reg_wdata == `FUPC_CMD_PROT_SEL);
      end
      if (reg_wr && reg_addr == `FUPC_ADDR_RATE_HI) begin
        rate_r[15:8] <= reg_wdata;
      end
      if (reg_wr && reg_addr == `FUPC_ADDR_RATE_LO) begin
        rate_r[7:0] <= reg_wdata;
      end
      if (wr_page && prot_map_r) begin
        // User sets only; debugger may write either way
        sect_prot_r <= dbg_sel ? reg_wdata :
                       (sect_prot_r | reg_wdata);
      end else if (wr_page && (state_r != `FUPC_ST_OPEN || dbg_sel)) begin
        page_sel_r <= reg_wdata;
        if (state_r == `FUPC_ST_UNLK1 && dbg_sel) begin
          active_page_r <= reg_wdata;
        end
      end
      if (state_r == `FUPC_ST_UNLK2 && state_nxt == `FUPC_ST_OPEN) begin
        active_page_r <= reg_wdata;
        open_mass_r   <= 1'b0;
      end
      if (state_r == `FUPC_ST_UNLK1 && state_nxt == `FUPC_ST_OPEN) begin
        active_page_r <= page_sel_r;
        open_mass_r   <= 1'b0;
      end
      if (state_r == `FUPC_ST_OPEN && state_nxt == `FUPC_ST_BUSY) begin
        timer_start_r <= 1'b1;
        erase_op_r    <= wr_cmd;
        timer_dur_r   <= wr_cmd ? erase_us : `FUPC_PROG_US;
        if (wr_cmd && reg_wdata == `FUPC_CMD_MASS_ERASE) begin
          fl_mass_erase_r <= 1'b1;
          open_mass_r     <= 1'b1;
        end else if (wr_cmd) begin
          // Whole page only, 8 rows of 64 bytes
          fl_page_erase_r <= 1'b1;
          fl_addr_r <= {3'b000, active_page_r[3:0], 9'h000};
        end else begin
          fl_prog_r  <= 1'b1;
          fl_addr_r  <= mem_addr;
          fl_wdata_r <= mem_wdata;
        end
      end
    end
  end

  // State readback shares the command address
  always @* begin
    reg_rdata = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        `FUPC_ADDR_CMD:     reg_rdata = {5'b00000, state_r};
        `FUPC_ADDR_PAGE:    reg_rdata = prot_map_r ? sect_prot_r :
                                        page_sel_r;
        `FUPC_ADDR_RATE_HI: reg_rdata = rate_r[15:8];
        `FUPC_ADDR_RATE_LO: reg_rdata = rate_r[7:0];
        default:            reg_rdata = 8'h00;
      endcase
    end
  end
endmodule

// ### fupc_map.vh
/*
 * Register offsets, command codes, field layouts and timing constants
 * of the flash unlock and protection controller.
 * Assumes an 8-bit register file port and a 40 MHz system clock.
 */
// How it works
// - Array erases in 512-byte pages of 8 rows of 64 bytes, or all program memory by mass erase.
// - Protection sector is 1024 bytes on largest size, 512 otherwise.
// - First two program memory bytes hold the option bits.
// - Information area FE00-FFFF is readable, never erased or written.
// - Software loads a 16-bit kHz clock rate before program or erase.
// - Readout protect bit blocks debugger reads of user code.
// - Program protect bit 0 blocks user program and erase.
// - Reset leaves the controller locked.
// - CPU unlock is page select, 73h, 8ch, page select again; debugger unlock ends at 8ch.
// - Differing page selects relock; matching ones set active page.
// - Command 95h erases the active page if its sector is open.
// - Any other command after unlock relocks the controller.
// - Mass erase is accepted only from the debug port.
// - Unlocked page accepts repeated byte writes and stays unlocked.
// - Any command write during byte writing relocks the page.
// - At most 8 sectors; a sector is never smaller than a page.
// - Sector protect resets to zero; user code cannot clear bits.
// - Command 5eh maps sector protect onto page select address.
// - User writes to sector protect only set bits.
// - Protect bits block CPU writes and page erases, not debugger ones.
// - Command register and state register share address ff8.
// - Debugger command 63h after unlock mass erases program memory.
// - Completed erase returns the controller to locked.
`ifndef FUPC_MAP_VH
`define FUPC_MAP_VH
`define FUPC_ADDR_CMD       12'hff8
`define FUPC_ADDR_PAGE      12'hff9
`define FUPC_ADDR_RATE_HI   12'hffa
`define FUPC_ADDR_RATE_LO   12'hffb
`define FUPC_CMD_UNLOCK1    8'h73
`define FUPC_CMD_UNLOCK2    8'h8c
`define FUPC_CMD_PAGE_ERASE 8'h95
`define FUPC_CMD_MASS_ERASE 8'h63
`define FUPC_CMD_PROT_SEL   8'h5e
`define FUPC_PAGE_BYTES     512
`define FUPC_ROW_BYTES      64
`define FUPC_ROWS_PER_PAGE  8
`define FUPC_MEM_BYTES      8192
`define FUPC_SECTOR_BYTES   1024
`define FUPC_OPT_BYTES      2
`define FUPC_INFO_BASE      16'hfe00
`define FUPC_PAGE_MSB       12
`define FUPC_PAGE_LSB       9
`define FUPC_SECT_MSB       12
`define FUPC_SECT_LSB       10
`define FUPC_PROG_US        16'd40
`define FUPC_ERASE_MS       16'd10
`define FUPC_RST_PROT       8'h00
`define FUPC_RST_RATE       16'h0000
`define FUPC_ST_LOCKED      3'd0
`define FUPC_ST_UNLK1       3'd1
`define FUPC_ST_UNLK2       3'd2
`define FUPC_ST_OPEN        3'd3
`define FUPC_ST_BUSY        3'd4
`endif

// ### fupc_timer.v
/*
 * Pulse timer: counts a duration given in microseconds against the
 * kHz clock-rate value, one tick per microsecond.
 * Assumes start is a single-cycle pulse and rate is nonzero.
 */
`timescale 1ns/10ps
`include "fupc_map.vh"
module fupc_timer (
  input  wire        clk,
  input  wire        sys_rst,
  input  wire        start,
  input  wire [15:0] rate_khz,
  input  wire [15:0] dur_us,
  output reg         busy_r,
  output wire        done
);
  reg  [15:0] frac_r;
  reg  [15:0] us_r;
  wire        tick;
  // One microsecond elapses when kHz/1000 clocks have passed
  assign tick = (frac_r + 16'd1000 >= rate_khz);
  assign done = busy_r && tick && (us_r == 16'd1);
  always @(posedge clk) begin
    if (sys_rst) begin
      busy_r <= 1'b0;
      frac_r <= 16'h0000;
      us_r   <= 16'h0000;
    end else if (start) begin
      busy_r <= 1'b1;
      frac_r <= 16'h0000;
      us_r   <= (dur_us == 16'h0000) ? 16'd1 : dur_us;
    end else if (busy_r) begin
      if (tick) begin
        frac_r <= frac_r + 16'd1000 - rate_khz;
        us_r   <= us_r - 16'd1;
        if (us_r == 16'd1) begin
          busy_r <= 1'b0;
        end
      end else begin
        frac_r <= frac_r + 16'd1000;
      end
    end
  end
endmodule

// ### fupc_ctrl_assertions.sv
/* Checker on the flash controller ports.
   Assumes a bind onto every fupc_ctrl instance. */
`timescale 1ns/10ps
module fupc_chk (
  input wire        clk,
  input wire        sys_rst,
  input wire        reg_wr,
  input wire [11:0] reg_addr,
  input wire [7:0]  reg_wdata,
  input wire        dbg_sel,
  input wire        program_protect_bit,
  input wire        readout_protect_bit,
  input wire        mem_wr,
  input wire        mem_rd,
  input wire [15:0] mem_addr,
  input wire        mem_rd_block,
  input wire        mem_wr_refused,
  input wire        fl_prog_r,
  input wire        fl_page_erase_r,
  input wire        fl_mass_erase_r,
  input wire [15:0] fl_addr_r,
  input wire        cpu_stall
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  rst_quiet_a: assert property (disable iff (1'b0) sys_rst |=>
    !fl_prog_r && !fl_page_erase_r && !fl_mass_erase_r) else $error("busy");
  prog_cause_a: assert property (fl_prog_r |->
    $past(mem_wr && !mem_wr_refused)) else $error("stray program");
  prog_addr_a: assert property (fl_prog_r |->
    fl_addr_r == $past(mem_addr)) else $error("program address");
  mass_dbg_a: assert property (fl_mass_erase_r |->
    $past(reg_wr && dbg_sel && reg_wdata == 8'h63)) else $error("mass");
  erase_cmd_a: assert property (fl_page_erase_r |->
    $past(reg_wr && reg_addr == 12'hff8 && reg_wdata == 8'h95))
    else $error("erase cause");
  erase_one_a: assert property (fl_page_erase_r |=>
    !fl_page_erase_r) else $error("erase pulse");
  erase_stall_a: assert property (fl_page_erase_r |->
    cpu_stall[*8]) else $error("erase stall");
  opt_block_a: assert property (mem_wr && !dbg_sel &&
    !program_protect_bit |-> mem_wr_refused) else $error("option bit");
  info_keep_a: assert property (mem_wr && !dbg_sel &&
    mem_addr >= 16'hfe00 |-> mem_wr_refused) else $error("info area");
  read_prot_a: assert property (mem_rd && dbg_sel &&
    readout_protect_bit && mem_addr < 16'h2000 |-> mem_rd_block)
    else $error("readout");
  cover property (fl_prog_r);
  cover property (fl_page_erase_r);
  cover property (fl_mass_erase_r);
endmodule
bind fupc_ctrl fupc_chk chk (.clk(clk), .sys_rst(sys_rst),
  .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .dbg_sel(dbg_sel), .program_protect_bit(program_protect_bit),
  .readout_protect_bit(readout_protect_bit), .mem_wr(mem_wr),
  .mem_rd(mem_rd), .mem_addr(mem_addr), .mem_rd_block(mem_rd_block),
  .mem_wr_refused(mem_wr_refused), .fl_prog_r(fl_prog_r),
  .fl_page_erase_r(fl_page_erase_r), .fl_mass_erase_r(fl_mass_erase_r),
  .fl_addr_r(fl_addr_r), .cpu_stall(cpu_stall));

// ### fupc_host_model.sv
/* CPU register bus and debug port model.
   Assumes the bench calls its tasks after reset. */
`timescale 1ns/10ps
module fupc_host_model (
  input  wire        clk,
  input  wire [7:0]  reg_rdata,
  input  wire        mem_wr_refused,
  input  wire        mem_rd_block,
  output logic       reg_wr,
  output logic       reg_rd,
  output logic [11:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic       dbg_sel,
  output logic       mem_wr,
  output logic       mem_rd,
  output logic [15:0] mem_addr,
  output logic [7:0] mem_wdata
);
  initial begin
    {reg_wr, reg_rd, dbg_sel, mem_wr, mem_rd} = 5'h00;
    {reg_addr, reg_wdata, mem_addr, mem_wdata} = 44'h0;
  end
  // Register write; idle bus shows inverted values
  task wr(input [11:0] a, input [7:0] d, input s);
    @(posedge clk);
    #1 {reg_wr, reg_addr, reg_wdata, dbg_sel} = {1'b1, a, d, s};
    @(posedge clk);
    #1 {reg_wr, reg_addr, reg_wdata} = {1'b0, ~a, ~d};
  endtask
  task rd(input [11:0] a, output [7:0] d);
    @(posedge clk);
    #1 {reg_rd, reg_addr} = {1'b1, a};
    @(posedge clk) d = reg_rdata;
    #1 {reg_rd, reg_addr} = {1'b0, ~a};
  endtask
  // Memory access: flag is refusal on write, block on read
  task mem(input w, input [15:0] a, input s, output f);
    @(posedge clk);
    #1 {mem_wr, mem_rd, mem_addr, mem_wdata, dbg_sel} = {w, !w, a, a[7:0], s};
    @(posedge clk) f = w ? mem_wr_refused : mem_rd_block;
    #1 {mem_wr, mem_rd, mem_addr, mem_wdata} = {2'b00, ~a, ~a[7:0]};
  endtask
endmodule

// ### test_flash_unlock_protect_ctrl.sv
/* Self-checking bench for the flash controller.
   Assumes the host model and the bound checker. */
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
  bad_count++; $display("ERROR %s exp %h got %h", nm, e, g); end end
module test_flash_unlock_protect_ctrl;
  logic clk = 0, sys_rst = 1, wp_bit = 1, rp_bit = 0;
  logic [7:0] rdata, v, fd;
  logic rdb, wrf, fp, fe, fm, stall, f;
  logic [15:0] fa;
  int bad_count = 0, n_compared = 0, cyc = 0, n_prog = 0, n_pe = 0, n_me = 0;
  wire w, r, ds, mw, mr;
  wire [11:0] ra;
  wire [7:0] wd, md;
  wire [15:0] ma;
  always #12.5 clk = ~clk;
  fupc_host_model h (.clk(clk), .reg_rdata(rdata), .mem_wr_refused(wrf),
    .mem_rd_block(rdb), .reg_wr(w), .reg_rd(r), .reg_addr(ra),
    .reg_wdata(wd), .dbg_sel(ds), .mem_wr(mw), .mem_rd(mr), .mem_addr(ma),
    .mem_wdata(md));
  fupc_ctrl dut (.clk(clk), .sys_rst(sys_rst), .reg_wr(w), .reg_rd(r),
    .reg_addr(ra), .reg_wdata(wd), .dbg_sel(ds), .reg_rdata(rdata),
    .program_protect_bit(wp_bit), .readout_protect_bit(rp_bit),
    .mem_wr(mw), .mem_rd(mr), .mem_addr(ma), .mem_wdata(md),
    .mem_rd_block(rdb), .mem_wr_refused(wrf), .fl_prog_r(fp),
    .fl_page_erase_r(fe), .fl_mass_erase_r(fm), .fl_addr_r(fa),
    .fl_wdata_r(fd), .cpu_stall(stall));
  always @(posedge clk) begin
    cyc++;
    if (fp === 1'b1) n_prog++;
    if (fe === 1'b1) n_pe++;
    if (fm === 1'b1) n_me++;
    if (cyc == 90000) begin
      bad_count++;
      finish_test();
    end
  end
  task finish_test();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task unlock(input [7:0] p, input [7:0] q);
    h.wr(12'hff9, p, 0);
    h.wr(12'hff8, 8'h73, 0);
    h.wr(12'hff8, 8'h8c, 0);
    h.wr(12'hff9, q, 0);
  endtask
  task wait_idle();
    repeat (3) @(posedge clk);
    for (int i = 0; i < 20000 && stall !== 1'b0; i++) @(posedge clk);
    `CHK("idle", 1'b0, stall)
  endtask
  task t_bytes();
    h.rd(12'hff8, v); `CHK("state", 8'h00, v)
    h.rd(12'hffb, v); `CHK("rate lo", 8'he8, v)
    h.mem(1, 16'h0400, 0, f); `CHK("locked wr", 1'b1, f)
    unlock(8'h02, 8'h02);
    h.rd(12'hff8, v); `CHK("open", 8'h03, v)
    h.mem(1, 16'h0405, 0, f); wait_idle();
    h.mem(1, 16'h0410, 0, f); `CHK("byte2", 1'b0, f)
    `CHK("addr", 16'h0410, fa)
    `CHK("wdata", 8'h10, fd)
    wait_idle(); `CHK("nprog", 2, n_prog)
    h.mem(1, 16'hfe00, 0, f); `CHK("info", 1'b1, f)
    h.wr(12'hff8, 8'h00, 0);
    h.rd(12'hff8, v); `CHK("relock", 8'h00, v)
    unlock(8'h02, 8'h03);
    h.rd(12'hff8, v); `CHK("mismatch", 8'h00, v)
    $display("bytes done");
  endtask
  task t_erase();
    unlock(8'h01, 8'h01); h.wr(12'hff8, 8'h95, 0);
    `CHK("stall", 1'b1, stall)
    wait_idle();
    `CHK("erase", 1, n_pe)
    h.rd(12'hff8, v); `CHK("post erase", 8'h00, v)
    unlock(8'h01, 8'h01); h.wr(12'hff8, 8'h63, 0);
    h.rd(12'hff8, v); `CHK("bad cmd", 8'h00, v)
    `CHK("cpu mass", 0, n_me)
    wp_bit = 0; unlock(8'h01, 8'h01); h.wr(12'hff8, 8'h95, 0); wait_idle();
    `CHK("opt bit", 1, n_pe)
    wp_bit = 1; $display("erase done");
  endtask
  task t_protect();
    h.wr(12'hff8, 8'h00, 0); h.wr(12'hff8, 8'h5e, 0);
    h.wr(12'hff9, 8'h01, 0); h.wr(12'hff9, 8'h00, 0);
    h.rd(12'hff9, v); `CHK("protect", 8'h01, v)
    h.wr(12'hff8, 8'h00, 0);
    unlock(8'h01, 8'h01); h.wr(12'hff8, 8'h95, 0); wait_idle();
    `CHK("sector", 1, n_pe)
    h.wr(12'hff8, 8'h73, 1); h.wr(12'hff8, 8'h8c, 1);
    h.wr(12'hff8, 8'h63, 1); wait_idle();
    `CHK("dbg mass", 1, n_me)
    rp_bit = 1; h.mem(0, 16'h0010, 1, f); `CHK("rd prot", 1'b1, f)
    @(posedge clk); #1 sys_rst = 1; @(posedge clk); #1 sys_rst = 0;
    h.wr(12'hff8, 8'h5e, 0);
    h.rd(12'hff9, v); `CHK("prot rst", 8'h00, v)
    $display("protect done");
  endtask
  initial begin
    repeat (12) @(posedge clk);
    #1 sys_rst = 0;
    h.wr(12'hffa, 8'h03, 0); h.wr(12'hffb, 8'he8, 0);
    t_bytes(); t_erase(); t_protect();
    finish_test();
  end
endmodule
